// ==== common/acs_pkg.sv ====
// package for the converter sequencer: register map, field layout, timing counts
// assumes a 32-bit axi4-lite slave with word-aligned registers
package acs_pkg;
    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [7:0] ACS_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] ACS_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] ACS_OFF_CTRL2 = 8'h08;
    localparam logic [7:0] ACS_OFF_RESULT = 8'h0c;
    localparam logic [7:0] ACS_OFF_PINFN = 8'h10;
    localparam logic [7:0] ACS_OFF_IRQ = 8'h14;
    localparam logic [7:0] ACS_OFF_SIGNAL = 8'h18;

    // ****************************************
    // control0 fields
    // ****************************************
    localparam int ACS_C0_CHAN_LSB = 0;
    localparam int ACS_C0_FORMAT = 4;
    localparam int ACS_C0_POWER = 5;
    localparam int ACS_C0_BUSY = 6;
    localparam int ACS_C0_START = 7;
    localparam logic [7:0] ACS_C0_RESET = 8'h00;

    // ****************************************
    // control1 fields
    // ****************************************
    localparam int ACS_C1_DIV_LSB = 0;
    localparam int ACS_C1_REF_LSB = 3;
    localparam int ACS_C1_SRC_LSB = 5;
    localparam logic [7:0] ACS_C1_RESET = 8'h00;

    // ****************************************
    // control2 fields
    // ****************************************
    localparam int ACS_C2_TEMP_SENSOR_ENABLE = 0;
    localparam int ACS_C2_FIXED = 1;
    localparam int ACS_C2_LOWCUR = 7;
    localparam logic [7:0] ACS_C2_RESET = 8'h02;

    // ****************************************
    // irq register fields
    // ****************************************
    localparam int ACS_IRQ_FLAG = 0;
    localparam int ACS_IRQ_CONV_EN = 1;
    localparam int ACS_IRQ_GLOBAL_EN = 2;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] ACS_REF_EXT_PIN = 2'h0;
    localparam logic [1:0] ACS_REF_TEMP = 2'h2;
    localparam logic [2:0] ACS_SRC_EXT_A = 3'h0;
    localparam logic [2:0] ACS_SRC_BANDGAP = 3'h1;
    localparam logic [2:0] ACS_SRC_TEMP = 3'h2;
    localparam logic [2:0] ACS_SRC_AMP0 = 3'h3;
    localparam logic [2:0] ACS_SRC_AMP1 = 3'h4;
    localparam logic [2:0] ACS_SRC_LINE = 3'h5;
    localparam logic [2:0] ACS_SRC_EXT_B = 3'h6;
    localparam logic [2:0] ACS_SRC_FORBIDDEN = 3'h7;
    localparam logic [3:0] ACS_CHAN_FIRST = 4'h2;
    localparam logic [3:0] ACS_CHAN_LAST = 4'h3;
    localparam logic [1:0] ACS_PIN_ANALOG = 2'h1;
    localparam logic [2:0] ACS_DIV_LOWCUR_MIN = 3'h4;

    // ****************************************
    // timing in converter clock periods, then axi response codes
    // ****************************************
    localparam logic [5:0] ACS_SAMPLE_NORMAL = 6'h04;
    localparam logic [5:0] ACS_SAMPLE_TEMP = 6'h2e;
    localparam logic [5:0] ACS_CONVERT_PERIODS = 6'h0c;
    localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;
endpackage

// ==== design/acs_sequencer.sv ====
// converter sequencer: control registers, source and reference steering, conversion timing
// assumes an axi4-lite master on aclk and an analog core that accepts sample/convert phase levels
// Function
// R1: ref_select 00 external pin, 01/11 analog supply, 10 temperature reference
// R2: software sets temp_sensor_enable when selecting temperature reference
// R3: software must not make reference pin an input under internal references
// R4: analog pin function disables other functions and its pull-high
// R5: analog pin function overrides the port direction setting
// R6: input_source_select picks external, bandgap, temperature, amplifiers or line amp
// R7: source code 111 is forbidden and treated as illegal
// R8: external source with channel 0010..0011 routes analog inputs two, three
// R9: software parks channel select on 0100..1111 before internal sources
// R10: nonexistent channel leaves external path unconnected and floating
// R11: non-temperature conversion is 4 sample plus 12 convert periods
// R12: temperature conversion is 46 sample plus 12 convert periods
// R13: conversion runs autonomously once started
// R14: start bit low-high-low pulse triggers a conversion
// R15: busy high during conversion, low on completion with result valid
// R16: software enables global and converter interrupts before starting
// R17: format select arranges result across high and low registers
// R18: software programs divider, mode, power, source, reference, then starts
// R19: converter clock is system clock divided by two to the divider field
// R20: completion sets request flag and raises interrupt when enabled
// R21: mode bit 0 normal, 1 low-current with slower clock range
// R22: start rise resets converter, start fall begins sampling and sets busy; the code ignores the fall while the power bit is low
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [11:0] core_data,
    output logic core_reset,
    output logic core_sample,
    output logic core_convert,
    output logic core_done,
    output logic [1:0] ref_select,
    output logic [2:0] input_source_select,
    output logic [1:0] ext_analog_inputs,
    output logic temp_sensor_enable,
    output logic converter_power_enable,
    output logic low_current_mode_select,
    output logic [1:0] pin_analog_mode,
    output logic [1:0] pin_pullup_allow,
    output logic [1:0] pin_dir_override,
    output logic conv_irq
);
    import acs_pkg::*;

    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_SAMPLE = 3'b010,
        ACS_CONVERT = 3'b100
    } acs_state_e;

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [3:0] pinfn_q;
    logic irq_flag_q;
    logic conv_en_q;
    logic global_en_q;
    logic [11:0] result_q;
    logic busy_q;
    logic start_q;
    acs_state_e state_q;
    logic [6:0] div_cnt_q;
    logic [5:0] period_cnt_q;
    logic aw_hold_q;
    logic [7:0] awaddr_q;
    logic w_hold_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic start_rise;
    logic start_fall;
    logic tick;
    logic [6:0] div_max;
    logic [2:0] src_sel;
    logic [3:0] chan_sel;
    logic is_temp_src;
    logic [15:0] res_hi_lo;

    // a write lane is used when byte 0 is strobed; upper bits carry nothing
    function automatic logic [7:0] acs_merge(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
        acs_merge = s[0] ? d[7:0] : old;
    endfunction

    // external source codes
    function automatic logic acs_is_ext(input logic [2:0] src);
        acs_is_ext = (src == ACS_SRC_EXT_A) || (src == ACS_SRC_EXT_B);
    endfunction

    // ****************************************
    // axi write channel
    // ****************************************
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign do_write = aw_hold_q && w_hold_q;

    // address and data are taken in either order, response once both are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ACS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    ACS_OFF_CTRL0, ACS_OFF_CTRL1, ACS_OFF_CTRL2, ACS_OFF_PINFN,
                    ACS_OFF_IRQ: s_axi_bresp <= ACS_RESP_OKAY;
                    default: s_axi_bresp <= ACS_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // software control registers
    // ****************************************
    // busy bit is read-only; forbidden source code keeps the old source
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl0_q <= ACS_C0_RESET;
            ctrl1_q <= ACS_C1_RESET;
            ctrl2_q <= ACS_C2_RESET;
            pinfn_q <= 4'h0;
            conv_en_q <= 1'b0;
            global_en_q <= 1'b0;
        end
        else if (do_write)
        begin
            if (awaddr_q == ACS_OFF_CTRL0)
                ctrl0_q <= acs_merge(ctrl0_q, wdata_q, wstrb_q);
            if (awaddr_q == ACS_OFF_CTRL1 && wstrb_q[0])
            begin
                ctrl1_q[4:0] <= wdata_q[4:0];
                if (wdata_q[7:5] != ACS_SRC_FORBIDDEN) // R7
                    ctrl1_q[7:5] <= wdata_q[7:5];
            end
            if (awaddr_q == ACS_OFF_CTRL2 && wstrb_q[0])
            begin
                ctrl2_q[ACS_C2_TEMP_SENSOR_ENABLE] <= wdata_q[ACS_C2_TEMP_SENSOR_ENABLE];
                ctrl2_q[ACS_C2_LOWCUR] <= wdata_q[ACS_C2_LOWCUR];
                ctrl2_q[ACS_C2_FIXED] <= wdata_q[ACS_C2_FIXED];
            end
            if (awaddr_q == ACS_OFF_PINFN && wstrb_q[0])
                pinfn_q <= wdata_q[3:0];
            if (awaddr_q == ACS_OFF_IRQ && wstrb_q[0])
            begin
                conv_en_q <= wdata_q[ACS_IRQ_CONV_EN];
                global_en_q <= wdata_q[ACS_IRQ_GLOBAL_EN];
            end
        end
    end

    // ****************************************
    // start pulse detect
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            start_q <= 1'b0;
        else
            start_q <= ctrl0_q[ACS_C0_START];
    end
    assign start_rise = ctrl0_q[ACS_C0_START] && !start_q; // R14
    assign start_fall = !ctrl0_q[ACS_C0_START] && start_q; // R14

    // ****************************************
    // converter clock divider
    // ****************************************
    // low-current mode floors the divider so the converter clock stays slow
    always_comb
    begin
        logic [2:0] sel;
        sel = ctrl1_q[ACS_C1_DIV_LSB +: 3];
        if (ctrl2_q[ACS_C2_LOWCUR] && sel < ACS_DIV_LOWCUR_MIN) // R21
            sel = ACS_DIV_LOWCUR_MIN;
        div_max = 7'((8'h01 << sel) - 8'h01); // R19
    end

    // divider restarts with each conversion so the first period is whole
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_cnt_q <= 7'h00;
        else if (start_fall || div_cnt_q >= div_max)
            div_cnt_q <= 7'h00;
        else
            div_cnt_q <= div_cnt_q + 7'h01;
    end
    assign tick = (div_cnt_q >= div_max);

    // ****************************************
    // conversion sequencer
    // ****************************************
    assign src_sel = ctrl1_q[ACS_C1_SRC_LSB +: 3];
    assign is_temp_src = (src_sel == ACS_SRC_TEMP);

    // runs on its own once triggered; rise aborts and resets the core
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ACS_IDLE;
            period_cnt_q <= 6'h00;
            busy_q <= 1'b0;
        end
        else if (start_rise)
        begin
            state_q <= ACS_IDLE; // R22
            busy_q <= 1'b0;
        end
        else if (start_fall && converter_power_enable)
        begin
            state_q <= ACS_SAMPLE; // R22
            busy_q <= 1'b1; // R15
            period_cnt_q <= is_temp_src ? ACS_SAMPLE_TEMP : ACS_SAMPLE_NORMAL; // R11 R12
        end
        else if (tick)
        begin
            unique case (state_q)
                ACS_IDLE: period_cnt_q <= 6'h00;
                ACS_SAMPLE:
                    if (period_cnt_q == 6'h01)
                    begin
                        state_q <= ACS_CONVERT;
                        period_cnt_q <= ACS_CONVERT_PERIODS; // R11 R12
                    end
                    else
                        period_cnt_q <= period_cnt_q - 6'h01;
                ACS_CONVERT:
                    if (period_cnt_q == 6'h01)
                    begin
                        state_q <= ACS_IDLE; // R13
                        busy_q <= 1'b0; // R15
                    end
                    else
                        period_cnt_q <= period_cnt_q - 6'h01;
            endcase
        end
    end
    assign core_done = (state_q == ACS_CONVERT) && tick && (period_cnt_q == 6'h01);

    // result captured in the completing cycle, so busy low means result valid
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            result_q <= 12'h000;
        else if (core_done && !start_rise)
            result_q <= core_data; // R15
    end

    // flag set wins over a software clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_flag_q <= 1'b0;
        else if (core_done && !start_rise)
            irq_flag_q <= 1'b1; // R20
        else if (do_write && awaddr_q == ACS_OFF_IRQ && wstrb_q[0] && !wdata_q[ACS_IRQ_FLAG])
            irq_flag_q <= 1'b0;
    end
    assign conv_irq = irq_flag_q && conv_en_q && global_en_q; // R20

    // ****************************************
    // analog steering
    // ****************************************
    assign chan_sel = ctrl0_q[ACS_C0_CHAN_LSB +: 4];
    assign ref_select = ctrl1_q[ACS_C1_REF_LSB +: 2]; // R1
    assign input_source_select = src_sel; // R6
    assign temp_sensor_enable = ctrl2_q[ACS_C2_TEMP_SENSOR_ENABLE];
    assign converter_power_enable = ctrl0_q[ACS_C0_POWER];
    assign low_current_mode_select = ctrl2_q[ACS_C2_LOWCUR]; // R21

    // one-hot switch per external input; other channels leave the path floating
    always_comb
    begin
        ext_analog_inputs = 2'b00; // R10
        if (acs_is_ext(src_sel) && chan_sel >= ACS_CHAN_FIRST && chan_sel <= ACS_CHAN_LAST)
            ext_analog_inputs[chan_sel[0]] = 1'b1; // R8
    end

    // per pin: analog mode kills other functions, pull-high and direction
    always_comb
    begin
        pin_analog_mode[0] = (pinfn_q[1:0] == ACS_PIN_ANALOG); // R4
        pin_analog_mode[1] = (pinfn_q[3:2] == ACS_PIN_ANALOG); // R4
        pin_pullup_allow = ~pin_analog_mode; // R4
        pin_dir_override = pin_analog_mode; // R5
    end

    assign core_reset = (state_q == ACS_IDLE);
    assign core_sample = (state_q == ACS_SAMPLE);
    assign core_convert = (state_q == ACS_CONVERT);

    // format 0: high holds bits 11..4; format 1: high holds bits 11..8
    assign res_hi_lo = ctrl0_q[ACS_C0_FORMAT] ? {4'h0, result_q} : {result_q, 4'h0}; // R17

    // ****************************************
    // axi read channel
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ACS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ACS_RESP_OKAY;
            case (s_axi_araddr)
                ACS_OFF_CTRL0: s_axi_rdata <= {24'h0, ctrl0_q[7], busy_q, ctrl0_q[5:0]};
                ACS_OFF_CTRL1: s_axi_rdata <= {24'h0, ctrl1_q};
                ACS_OFF_CTRL2: s_axi_rdata <= {24'h0, ctrl2_q};
                ACS_OFF_RESULT: s_axi_rdata <= {16'h0, res_hi_lo};
                ACS_OFF_PINFN: s_axi_rdata <= {28'h0, pinfn_q};
                ACS_OFF_IRQ: s_axi_rdata <= {29'h0, global_en_q, conv_en_q, irq_flag_q};
                ACS_OFF_SIGNAL: s_axi_rdata <= {25'h0, state_q, ext_analog_inputs, tick, busy_q};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= ACS_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// ==== testbench/acs_sequencer_monitor.sv ====
// checker for the sequencer: phase lengths, steering interlocks, pin overrides
// assumes it is bound onto acs_sequencer and sees only that module's ports
`timescale 1ns/1ps
module acs_sequencer_monitor
    import acs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_reset,
    input wire logic core_sample,
    input wire logic core_convert,
    input wire logic core_done,
    input wire logic [2:0] input_source_select,
    input wire logic [1:0] ext_analog_inputs,
    input wire logic [1:0] pin_analog_mode,
    input wire logic [1:0] pin_pullup_allow,
    input wire logic [1:0] pin_dir_override
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [15:0] smp_q;
    logic [15:0] cnv_q;
    // ****************************************
    // phase counters
    // ****************************************
    // cleared while the core is held reset, so an aborted run leaves no residue
    always_ff @(posedge aclk)
    begin
        if (!aresetn || core_reset)
        begin
            smp_q <= 16'h0000;
            cnv_q <= 16'h0000;
        end
        else
        begin
            smp_q <= smp_q + {15'h0000, core_sample};
            cnv_q <= cnv_q + {15'h0000, core_convert};
        end
    end
    // ****************************************
    // properties
    // ****************************************
    // ratios hold for every divider setting, so no divider port is needed
    sequence done_s;
        core_convert && core_done;
    endsequence
    sequence idle_s;
        !core_convert && !core_sample && !core_done;
    endsequence
    ratio_normal_a: assert property (done_s and (input_source_select != ACS_SRC_TEMP)
        |-> (cnv_q + 16'h0001) == 3 * smp_q) else $error("sample to convert ratio off");
    ratio_temp_a: assert property (done_s and (input_source_select == ACS_SRC_TEMP)
        |-> 23 * (cnv_q + 16'h0001) == 6 * smp_q) else $error("temp sample ratio off");
    done_ends_a: assert property (done_s |=> idle_s) else $error("phase after done");
    start_idle_a: assert property ($rose(core_sample) |-> $past(core_reset))
        else $error("sampling began without reset");
    abort_hold_a: assert property (core_reset |-> !core_sample && !core_convert)
        else $error("phase active in reset");
    src_legal_a: assert property (input_source_select != ACS_SRC_FORBIDDEN)
        else $error("forbidden source");
    route_ext_a: assert property (|ext_analog_inputs |-> ext_analog_inputs != 2'h3
        && (input_source_select == ACS_SRC_EXT_A || input_source_select == ACS_SRC_EXT_B))
        else $error("external route bad");
    pin_pull_a: assert property ((pin_analog_mode & pin_pullup_allow) == 2'h0)
        else $error("pull-high on analog pin");
    pin_dir_a: assert property (pin_dir_override == pin_analog_mode)
        else $error("direction override off");
endmodule
bind acs_sequencer acs_sequencer_monitor i_acs_sequencer_monitor (.*);

// ==== testbench/acs_core_model.sv ====
// behavioural analog core: gives a code while converting, churn otherwise
// assumes the sequencer's level phase outputs and its one-cycle done pulse
`timescale 1ns/1ps
module acs_core_model
(
    input wire logic aclk,
    input wire logic core_convert,
    input wire logic core_done,
    output logic [11:0] core_data
);
    logic [11:0] n_q = 12'h000;
    logic [11:0] pat_q = 12'h000;
    // churn outside the convert phase so a mistimed capture is seen
    always_ff @(posedge aclk)
    begin
        pat_q <= pat_q + 12'h3b7;
        if (core_done)
            n_q <= n_q + 12'h001;
    end
    assign core_data = core_convert ? (12'h5a3 + n_q) : pat_q;
endmodule

// ==== testbench/adc_conversion_sequencer_tb_top.sv ====
// bench: register and conversion tests through axi4-lite calls
// assumes acs_sequencer with the register map of acs_pkg
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
    import acs_pkg::*;
    logic aclk;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, ref_select, ext_analog_inputs;
    logic [1:0] pin_analog_mode, pin_pullup_allow, pin_dir_override;
    logic [2:0] input_source_select;
    logic [11:0] core_data;
    logic core_reset, core_sample, core_convert, core_done, temp_sensor_enable;
    logic converter_power_enable, low_current_mode_select, conv_irq;
    int n_mismatch = 0;
    int checked = 0;
    int ncv = 0;
    int i;
    logic [11:0] res;
    acs_sequencer i_acs_sequencer (.*);
    acs_core_model i_acs_core_model (.aclk, .core_convert, .core_done, .core_data);
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // ****************************************
    // helpers
    // ****************************************
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task tmo;
        n_mismatch++;
        $display("BAD wait expected done seen hang");
        report_and_stop;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // each call starts on a fresh edge, so no strobe is driven twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        @(posedge aclk);
        ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                s_axi_bready <= 1'b0;
                ok = 1'b1;
                chk("bresp", 32'h0, 32'(s_axi_bresp));
            end
        end
        if (!ok)
            tmo;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic ok;
        @(posedge aclk);
        ok = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                s_axi_rready <= 1'b0;
                ok = 1'b1;
                chk(nm, e, s_axi_rdata);
                chk("rresp", 32'(er), 32'(s_axi_rresp));
            end
        end
        if (!ok)
            tmo;
    endtask
    // start pulse, then count the phase cycles up to the done pulse
    task automatic conv(input logic [7:0] c0, input int es, input int ec);
        int ns;
        int nc;
        int nd;
        wr(ACS_OFF_CTRL0, c0 | 8'h80);
        wr(ACS_OFF_CTRL0, c0);
        ns = 0;
        nc = 0;
        nd = 0;
        for (int n = 0; n < 20000 && nd == 0; n++)
        begin
            @(posedge aclk);
            ns += int'(core_sample === 1'b1);
            nc += int'(core_convert === 1'b1);
            nd += int'(core_done === 1'b1);
        end
        if (nd == 0)
            tmo;
        chk("sample", es, ns);
        chk("convert", ec, nc);
        res = 12'h5a3 + ncv[11:0];
        ncv++;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("ctrl0", ACS_OFF_CTRL0, 32'h0, ACS_RESP_OKAY);
        rchk("ctrl1", ACS_OFF_CTRL1, 32'h0, ACS_RESP_OKAY);
        rchk("ctrl2", ACS_OFF_CTRL2, 32'h2, ACS_RESP_OKAY);
        rchk("irq", ACS_OFF_IRQ, 32'h0, ACS_RESP_OKAY);
        rchk("hole", 8'h1c, 32'h0, ACS_RESP_SLVERR);
        wr(ACS_OFF_CTRL0, 8'h40);
        rchk("busy ro", ACS_OFF_CTRL0, 32'h0, ACS_RESP_OKAY);
        $display("test registers done");
        wr(ACS_OFF_CTRL2, 8'h03);
        for (i = 0; i < 4; i++)
        begin
            wr(ACS_OFF_CTRL1, 8'(i << 3));
            chk("ref", 32'(i), 32'(ref_select));
        end
        wr(ACS_OFF_CTRL0, 8'h04);
        for (i = 0; i < 7; i++)
        begin
            wr(ACS_OFF_CTRL1, 8'(i << 5) | 8'h08);
            chk("src", 32'(i), 32'(input_source_select));
            chk("ext", 32'h0, 32'(ext_analog_inputs));
        end
        wr(ACS_OFF_CTRL1, 8'he8);
        rchk("src7", ACS_OFF_CTRL1, 32'hc8, ACS_RESP_OKAY);
        for (i = 0; i < 6; i++)
        begin
            wr(ACS_OFF_CTRL0, 8'(i));
            chk("route", (i == 2) ? 32'h1 : (i == 3) ? 32'h2 : 32'h0,
                32'(ext_analog_inputs));
        end
        $display("test steering done");
        for (i = 0; i < 2; i++)
        begin
            wr(ACS_OFF_PINFN, (i == 0) ? 8'h09 : 8'h04);
            chk("analog", 32'(i + 1), 32'(pin_analog_mode));
            chk("pull", 32'(2 - i), 32'(pin_pullup_allow));
            chk("dir", 32'(i + 1), 32'(pin_dir_override));
        end
        $display("test pins done");
        wr(ACS_OFF_CTRL1, 8'h09);
        wr(ACS_OFF_CTRL2, 8'h02);
        wr(ACS_OFF_IRQ, 8'h06);
        conv(8'h22, 8, 24);
        rchk("res f0", ACS_OFF_RESULT, {16'h0, res, 4'h0}, ACS_RESP_OKAY);
        rchk("done", ACS_OFF_CTRL0, 32'h22, ACS_RESP_OKAY);
        chk("irq on", 32'h1, 32'(conv_irq));
        rchk("flag", ACS_OFF_IRQ, 32'h7, ACS_RESP_OKAY);
        wr(ACS_OFF_IRQ, 8'h06);
        chk("irq off", 32'h0, 32'(conv_irq));
        wr(ACS_OFF_CTRL2, 8'h03);
        wr(ACS_OFF_CTRL0, 8'h34);
        wr(ACS_OFF_CTRL1, 8'h50);
        conv(8'h34, 46, 12);
        rchk("res f1", ACS_OFF_RESULT, {20'h0, res}, ACS_RESP_OKAY);
        wr(ACS_OFF_CTRL1, 8'h28);
        wr(ACS_OFF_CTRL2, 8'h83);
        chk("lvl", 32'h7, {29'h0, temp_sensor_enable, converter_power_enable,
            low_current_mode_select});
        conv(8'h24, 64, 192);
        $display("test conversions done");
        wr(ACS_OFF_CTRL2, 8'h02);
        wr(ACS_OFF_CTRL1, 8'h0f);
        wr(ACS_OFF_CTRL0, 8'ha2);
        wr(ACS_OFF_CTRL0, 8'h22);
        rchk("busy", ACS_OFF_CTRL0, 32'h62, ACS_RESP_OKAY);
        wr(ACS_OFF_CTRL0, 8'ha2);
        repeat (2) @(posedge aclk);
        chk("abort", 32'h1, 32'(core_reset & ~core_sample & ~core_convert));
        wr(ACS_OFF_CTRL0, 8'h02);
        for (i = 0; i < 20; i++)
        begin
            @(posedge aclk);
            if (core_sample !== 1'b0)
                chk("unpowered", 32'h0, 32'(core_sample));
        end
        rchk("idle", ACS_OFF_CTRL0, 32'h02, ACS_RESP_OKAY);
        $display("test abort done");
        report_and_stop;
    end
endmodule
